/* File: rtl/sbc_pkg.sv */
package sbc_pkg;

   // Access size encoding, shared by bus requests and the abort size field
   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_HALF = 2'h1,
      SZ_WORD = 2'h2,
      SZ_RSVD = 2'h3
   } acc_size_t;

   // Access type encoding, shared by bus requests and the abort type field
   typedef enum logic [1:0] {
      ACC_READ  = 2'h0,
      ACC_WRITE = 2'h1,
      ACC_FETCH = 2'h2,
      ACC_RSVD  = 2'h3
   } acc_type_t;

   // Slave selected by the address decoder
   typedef enum logic [1:0] {
      TGT_NONE,
      TGT_FLASH,
      TGT_SRAM,
      TGT_PERIPH
   } target_t;

   // One master's request towards the controller
   typedef struct packed {
      logic        req;
      logic [31:0] addr;
      logic [31:0] wdata;
      acc_size_t   size;
      acc_type_t   kind;
   } bus_req_t;

   // Access handed on to the selected slave, one cycle after acceptance
   typedef struct packed {
      logic        valid;
      target_t     target;
      logic [27:0] offset;
      logic        write;
      acc_size_t   size;
      logic [31:0] wdata;
   } slave_req_t;

   // Decoder result
   typedef struct packed {
      target_t     target;
      logic [27:0] offset;
      logic        undefined;
   } decode_t;

   // Register offsets (byte addresses on the register port)
   localparam logic [7:0]  REMAP_CMD_OFS   = 8'h00;
   localparam logic [7:0]  ABORT_STAT_OFS  = 8'h04;
   localparam logic [7:0]  ABORT_ADDR_OFS  = 8'h08;

   // Remap command field
   localparam int          REMAP_TOGGLE_BIT = 0;

   // Abort status field positions
   localparam int          UNDEF_FLAG_BIT  = 0;
   localparam int          MISAL_FLAG_BIT  = 1;
   localparam int          ABT_SIZE_LSB    = 8;
   localparam int          ABT_TYPE_LSB    = 10;
   localparam int          DMA_SRC_BIT     = 16;
   localparam int          CPU_SRC_BIT     = 17;
   localparam int          DMA_STICKY_BIT  = 24;
   localparam int          CPU_STICKY_BIT  = 25;

   // Values after reset
   localparam logic [31:0] ABORT_STAT_RST  = 32'h0000_0000;
   localparam logic [31:0] ABORT_ADDR_RST  = 32'h0000_0000;
   localparam logic        REMAP_RST       = 1'b0;

   // Address map
   localparam logic [3:0]  REGION_INTERNAL = 4'h0;
   localparam logic [3:0]  REGION_PERIPH   = 4'hf;
   localparam logic [7:0]  SLOT_AREA0      = 8'h00;
   localparam logic [7:0]  SLOT_FLASH      = 8'h01;
   localparam logic [7:0]  SLOT_SRAM       = 8'h02;

   // Memory sizes as address widths (flash 256 kbyte, SRAM 64 kbyte)
   localparam int          FLASH_AW        = 18;
   localparam int          SRAM_AW         = 16;

endpackage

/* File: rtl/region_decoder.sv */
`timescale 1ns/1ps
`default_nettype none

module region_decoder
   import sbc_pkg::*;
(
   // Request address and map state
   input  wire logic [31:0] addr_i,
   input  wire logic        remap_i,
   // Decode result
   output decode_t          dec_o
);

   // Keep only the low bits that a memory of 2**aw bytes sees
   function automatic logic [27:0] alias_offset(input logic [31:0] a, input int aw);
      logic [27:0] mask;
      mask = 28'((28'h1 << aw) - 28'h1);
      return a[27:0] & mask;
   endfunction

   // Region, then slot, then aliasing inside the slot
   always_comb begin
      dec_o.target    = TGT_NONE;
      dec_o.offset    = 28'h0;
      dec_o.undefined = 1'b1;
      if (addr_i[31:28] == REGION_INTERNAL) begin
         case (addr_i[27:20])
            SLOT_AREA0: begin
               dec_o.target    = remap_i ? TGT_SRAM : TGT_FLASH;
               dec_o.offset    = alias_offset(addr_i, remap_i ? SRAM_AW : FLASH_AW);
               dec_o.undefined = 1'b0;
            end
            SLOT_FLASH: begin
               dec_o.target    = TGT_FLASH;
               dec_o.offset    = alias_offset(addr_i, FLASH_AW);
               dec_o.undefined = 1'b0;
            end
            SLOT_SRAM: begin
               dec_o.target    = TGT_SRAM;
               dec_o.offset    = alias_offset(addr_i, SRAM_AW);
               dec_o.undefined = 1'b0;
            end
            default: begin
               dec_o.undefined = 1'b1;
            end
         endcase
      end else if (addr_i[31:28] == REGION_PERIPH) begin
         dec_o.target    = TGT_PERIPH;
         dec_o.offset    = addr_i[27:0];
         dec_o.undefined = 1'b0;
      end else begin
         dec_o.undefined = 1'b1;
      end
   end

endmodule // region_decoder

`default_nettype wire

/* File: rtl/system_bus_controller.sv */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - DMA master beats processor when both request
// - Top four address bits pick a region
// - Region 0 internal, region F peripherals
// - Fourteen middle regions are undefined, abort
// - Eight more bits pick a 1-Mbyte slot
// - Small memory aliases across its slot
// - Unassigned internal slot aborts
// - Area 0 is flash, SRAM after remap
// - Mapped memory also stays at own slot
// - Writing one toggles remap, zero ignored
// - Abort goes to every master
// - Abort address register keeps full address
// - Abort size and type are recorded
// - Undefined and misaligned cause flags recorded
// - Source bits name the aborting master
// - Sticky per-master flag for unreported aborts
// - Misaligned word access aborts
// - Misaligned half-word access aborts
// - Processor instruction fetches skip alignment check
// - Little-endian transfers only
// - Reading abort status clears sticky flags
module system_bus_controller
   import sbc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   // Bus masters
   input  wire bus_req_t    dma_req_i,
   input  wire bus_req_t    cpu_req_i,
   output logic             dma_gnt_o,
   output logic             cpu_gnt_o,
   output logic             abort_o,
   // Slave side
   output slave_req_t       slave_o,
   output logic             remap_o,
   // Register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [31:0]      reg_rdata_o
);

   // Whole state of the controller
   typedef struct packed {
      logic        remap;       // Area 0 shows SRAM when set
      slave_req_t  slv;         // Registered access to the slave
      logic        abort;       // Abort pulse to all masters
      logic        undef_flag;  // Last abort: undefined address
      logic        misal_flag;  // Last abort: misaligned address
      acc_size_t   abt_size;    // Last abort size
      acc_type_t   abt_type;    // Last abort type
      logic [1:0]  src;         // Last abort source, bit 0 DMA, bit 1 CPU
      logic [1:0]  sticky;      // Aborts not shown in src since read
      logic        unread;      // src holds an abort not yet read
      logic [31:0] abt_addr;    // Last abort address
      logic [31:0] rdata;       // Register read data
   } state_t;

   state_t     st_r;            // Registered state
   state_t     st_nxt;          // Next state
   decode_t    dec;             // Decode of the granted address
   bus_req_t   cur;             // Granted request
   logic       gnt_dma;         // DMA owns the bus this cycle
   logic       gnt_cpu;         // Processor owns the bus this cycle
   logic       active;          // Some master was granted
   logic       misaligned;      // Granted access fails alignment
   logic       abort_now;       // Granted access is cancelled
   logic       rd_status;       // Software reads abort status

   // Alignment check for one request
   function automatic logic is_misaligned(input bus_req_t r, input logic from_cpu);
      logic bad;
      bad = 1'b0;
      // word needs both low bits zero
      if (r.size == SZ_WORD && r.addr[1:0] != 2'h0) begin
         bad = 1'b1;
      end
      if (r.size == SZ_HALF && r.addr[0]) begin
         bad = 1'b1;
      end
      if (from_cpu && r.kind == ACC_FETCH) begin
         bad = 1'b0;
      end
      return bad;
   endfunction

   // Abort status word as software sees it
   function automatic logic [31:0] status_word(input state_t s);
      logic [31:0] w;
      w = ABORT_STAT_RST;
      w[UNDEF_FLAG_BIT]                 = s.undef_flag;
      w[MISAL_FLAG_BIT]                 = s.misal_flag;
      w[ABT_SIZE_LSB +: 2]              = s.abt_size;
      w[ABT_TYPE_LSB +: 2]              = s.abt_type;
      w[DMA_SRC_BIT]                    = s.src[0];
      w[CPU_SRC_BIT]                    = s.src[1];
      w[DMA_STICKY_BIT]                 = s.sticky[0];
      w[CPU_STICKY_BIT]                 = s.sticky[1];
      return w;
   endfunction

   // Fixed priority arbiter, combinational so a master learns at once
   always_comb begin
      gnt_dma = dma_req_i.req;
      gnt_cpu = cpu_req_i.req & ~dma_req_i.req;
      active  = gnt_dma | gnt_cpu;
      cur     = gnt_dma ? dma_req_i : cpu_req_i;
   end

   // Address decoder on the granted address
   region_decoder u_decoder (
      .addr_i  (cur.addr),
      .remap_i (st_r.remap),
      .dec_o   (dec)
   );

   // Cancel decision
   always_comb begin
      misaligned = active & is_misaligned(cur, gnt_cpu);
      abort_now  = active & (dec.undefined | misaligned);
      rd_status  = reg_rd_i & (reg_addr_i == ABORT_STAT_OFS);
   end

   // Next state: slave stage, abort record, registers
   always_comb begin
      st_nxt = st_r;

      // cancelled access never reaches a slave
      st_nxt.slv.valid  = active & ~abort_now;
      st_nxt.slv.target = dec.target;
      st_nxt.slv.offset = dec.offset;
      // Byte lanes pass unswapped; the only byte order is little-endian
      // little-endian pass-through
      st_nxt.slv.write  = cur.kind == ACC_WRITE;
      st_nxt.slv.size   = cur.size;
      st_nxt.slv.wdata  = cur.wdata;

      // one abort line for all masters
      st_nxt.abort = abort_now;

      if (rd_status) begin
         st_nxt.sticky = 2'h0;
         st_nxt.unread = 1'b0;
      end

      // Abort applied after the read clear so a same-cycle abort is kept
      if (abort_now) begin
         if (st_nxt.unread) begin
            st_nxt.sticky = st_nxt.sticky | st_r.src;
         end
         st_nxt.src        = {gnt_cpu, gnt_dma};
         st_nxt.unread     = 1'b1;
         st_nxt.abt_addr   = cur.addr;
         st_nxt.abt_size   = cur.size;
         st_nxt.abt_type   = cur.kind;
         st_nxt.undef_flag = dec.undefined;
         st_nxt.misal_flag = misaligned;
      end

      if (reg_wr_i && reg_addr_i == REMAP_CMD_OFS && reg_wdata_i[REMAP_TOGGLE_BIT]) begin
         st_nxt.remap = ~st_r.remap;
      end

      // Read data stand one cycle only, zero otherwise and when unmapped
      st_nxt.rdata = 32'h0;
      if (reg_rd_i) begin
         case (reg_addr_i)
            ABORT_STAT_OFS: begin
               st_nxt.rdata = status_word(st_r);
            end
            ABORT_ADDR_OFS: begin
               st_nxt.rdata = st_r.abt_addr;
            end
            // Remap command is write-only
            default: begin
               st_nxt.rdata = 32'h0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         st_r            <= '0;
         st_r.remap      <= REMAP_RST;
         st_r.abt_addr   <= ABORT_ADDR_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign dma_gnt_o   = gnt_dma;
   assign cpu_gnt_o   = gnt_cpu;
   // masters filter the shared abort themselves
   assign abort_o     = st_r.abort;
   assign slave_o     = st_r.slv;
   assign remap_o     = st_r.remap;
   assign reg_rdata_o = st_r.rdata;

   // Checks

   property p_priority;
      @(posedge clk_sys_i) disable iff (rst_i)
      dma_req_i.req |-> (dma_gnt_o && !cpu_gnt_o);
   endproperty
   a_priority: assert property (p_priority) else $error("cpu granted over dma");

   property p_undef_region;
      @(posedge clk_sys_i) disable iff (rst_i)
      (active && cur.addr[31:28] != REGION_INTERNAL && cur.addr[31:28] != REGION_PERIPH)
         |=> (abort_o && st_r.undef_flag && !slave_o.valid);
   endproperty
   a_undef_region: assert property (p_undef_region)
      else $error("undefined region not aborted");

   property p_bad_slot;
      @(posedge clk_sys_i) disable iff (rst_i)
      (active && cur.addr[31:28] == REGION_INTERNAL && cur.addr[27:20] > SLOT_SRAM) |=> abort_o;
   endproperty
   a_bad_slot: assert property (p_bad_slot) else $error("unassigned slot not aborted");

   property p_area0;
      @(posedge clk_sys_i) disable iff (rst_i)
      (active && cur.addr[31:20] == 12'h000 && !abort_now)
         |=> slave_o.target == ($past(st_r.remap) ? TGT_SRAM : TGT_FLASH);
   endproperty
   a_area0: assert property (p_area0) else $error("area 0 maps wrong memory");

   property p_toggle;
      @(posedge clk_sys_i) disable iff (rst_i)
      (reg_wr_i && reg_addr_i == REMAP_CMD_OFS) |=>
         (remap_o == ($past(remap_o) ^ $past(reg_wdata_i[REMAP_TOGGLE_BIT])));
   endproperty
   a_toggle: assert property (p_toggle) else $error("remap toggle wrong");

   property p_addr_saved;
      @(posedge clk_sys_i) disable iff (rst_i)
      abort_now |=> (st_r.abt_addr == $past(cur.addr) && abort_o);
   endproperty
   a_addr_saved: assert property (p_addr_saved) else $error("abort address not saved");

   property p_source;
      @(posedge clk_sys_i) disable iff (rst_i)
      abort_now |=> st_r.src == {$past(gnt_cpu), $past(gnt_dma)};
   endproperty
   a_source: assert property (p_source) else $error("abort source wrong");

   property p_word_misal;
      @(posedge clk_sys_i) disable iff (rst_i)
      (active && cur.size == SZ_WORD && cur.addr[1:0] != 2'h0
         && !(gnt_cpu && cur.kind == ACC_FETCH))
         |=> (abort_o && st_r.misal_flag && !slave_o.valid);
   endproperty
   a_word_misal: assert property (p_word_misal) else $error("misaligned word passed");

   property p_half_misal;
      @(posedge clk_sys_i) disable iff (rst_i)
      (active && cur.size == SZ_HALF && cur.addr[0] && !(gnt_cpu && cur.kind == ACC_FETCH))
         |=> (abort_o && st_r.misal_flag);
   endproperty
   a_half_misal: assert property (p_half_misal)
      else $error("misaligned half-word passed");

   property p_fetch_exempt;
      @(posedge clk_sys_i) disable iff (rst_i)
      (gnt_cpu && cur.kind == ACC_FETCH && !dec.undefined) |=> !abort_o;
   endproperty
   a_fetch_exempt: assert property (p_fetch_exempt)
      else $error("fetch aborted on alignment");

   // A same-cycle abort stays unread and never lands in sticky
   property p_read_clear;
      @(posedge clk_sys_i) disable iff (rst_i)
      rd_status |=> (st_r.sticky == 2'h0 && st_r.unread == $past(abort_now));
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("sticky not cleared by read");

   property p_sticky;
      @(posedge clk_sys_i) disable iff (rst_i)
      (abort_now && st_r.unread && !rd_status)
         |=> (st_r.sticky == ($past(st_r.sticky) | $past(st_r.src)));
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky flag not set");

   property p_abort_info;
      @(posedge clk_sys_i) disable iff (rst_i)
      abort_now |=> (st_r.abt_size == $past(cur.size) && st_r.abt_type == $past(cur.kind));
   endproperty
   a_abort_info: assert property (p_abort_info)
      else $error("abort size or type wrong");

   // A byte access is never misaligned, so only the undefined flag rises
   property p_undef_cause;
      @(posedge clk_sys_i) disable iff (rst_i)
      (active && cur.size == SZ_BYTE && cur.addr[31:28] != REGION_INTERNAL
         && cur.addr[31:28] != REGION_PERIPH) |=> (st_r.undef_flag && !st_r.misal_flag);
   endproperty
   a_undef_cause: assert property (p_undef_cause)
      else $error("abort cause flags wrong");

   property p_periph;
      @(posedge clk_sys_i) disable iff (rst_i)
      (active && cur.addr[31:28] == REGION_PERIPH && !misaligned)
         |=> (slave_o.valid && slave_o.target == TGT_PERIPH);
   endproperty
   a_periph: assert property (p_periph) else $error("peripheral access lost");

   property p_sram_slot;
      @(posedge clk_sys_i) disable iff (rst_i)
      (active && cur.addr[31:20] == {REGION_INTERNAL, SLOT_SRAM} && !misaligned)
         |=> (slave_o.valid && slave_o.target == TGT_SRAM);
   endproperty
   a_sram_slot: assert property (p_sram_slot) else $error("SRAM slot not reached");

   // Flash is smaller than its slot, so upper offset bits must drop out
   property p_flash_alias;
      @(posedge clk_sys_i) disable iff (rst_i)
      (active && cur.addr[31:20] == {REGION_INTERNAL, SLOT_FLASH} && !misaligned)
         |=> (slave_o.valid && slave_o.offset == 28'($past(cur.addr[FLASH_AW-1:0])));
   endproperty
   a_flash_alias: assert property (p_flash_alias)
      else $error("flash slot alias wrong");

   c_dma_abort: cover property (@(posedge clk_sys_i) disable iff (rst_i) abort_now && gnt_dma);
   c_cpu_misal: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      abort_now && misaligned && gnt_cpu);
   c_remapped:  cover property (@(posedge clk_sys_i) disable iff (rst_i) remap_o && slave_o.valid);
   c_sticky:    cover property (@(posedge clk_sys_i) disable iff (rst_i) st_r.sticky == 2'h3);
   c_contend:   cover property (@(posedge clk_sys_i) disable iff (rst_i)
      dma_req_i.req && cpu_req_i.req);

endmodule // system_bus_controller

`default_nettype wire

/* File: tb/bus_masters_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Processor and DMA masters, steered by the bench through drive and idle
module bus_masters_model
   import sbc_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_i,
   // Controller answers
   input  wire logic cpu_gnt_i,
   input  wire logic abort_i,
   // Requests
   output var bus_req_t dma_req_o,
   output var bus_req_t cpu_req_o,
   // Aborts the processor took as its own
   output var int       cpu_aborts_o
);
   logic cpu_taken_r;   // Processor access taken at the last edge

   initial begin
      dma_req_o = '0;
      cpu_req_o = '0;
   end

   // little endian only
   // Write data go out as given, byte 0 in bits 7:0, never swapped
   task automatic drive(input bit cpu, input logic [31:0] a, input acc_size_t sz,
                        input acc_type_t k, input logic [31:0] d);
      bus_req_t r;
      r = '{req: 1'b1, addr: a, wdata: d, size: sz, kind: k};
      if (cpu) begin
         cpu_req_o <= r;
      end else begin
         dma_req_o <= r;
      end
   endtask

   // Released address and data lines show inverted values, so a stale request cannot pass
   task automatic idle(input bit cpu);
      bus_req_t r;
      r = cpu ? cpu_req_o : dma_req_o;
      r.req = 1'b0;
      r.addr = ~r.addr;
      r.wdata = ~r.wdata;
      if (cpu) begin
         cpu_req_o <= r;
      end else begin
         dma_req_o <= r;
      end
   endtask

   // own aborts only
   // DMA side ignores the abort; processor counts it only after its own access
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         cpu_taken_r <= 1'b0;
         cpu_aborts_o <= 0;
      end else begin
         cpu_taken_r <= cpu_req_o.req & cpu_gnt_i;
         if (abort_i && cpu_taken_r) begin
            cpu_aborts_o <= cpu_aborts_o + 1;
         end
      end
   end
endmodule // bus_masters_model

`default_nettype wire

/* File: tb/tb_system_bus_controller.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_system_bus_controller
   import sbc_pkg::*;
;
   logic        clk_sys_i;
   logic        rst_i;
   bus_req_t    dma_req;
   bus_req_t    cpu_req;
   logic        dma_gnt;
   logic        cpu_gnt;
   logic        abort;
   slave_req_t  slave;
   logic        remap;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   int          cpu_aborts;
   int          num_errors;
   int          checks_done;
   // Reference model state
   bit          m_remap;
   bit [1:0]    m_src;
   bit [1:0]    m_sticky;
   bit          m_unread;
   logic [31:0] m_stat;
   logic [31:0] m_aaddr;
   int          m_cpu_ab;
   logic [31:0] seed;
   logic [31:0] a1;
   logic [31:0] a2;
   acc_size_t   s1;
   acc_size_t   s2;
   acc_type_t   k1;
   acc_type_t   k2;

   system_bus_controller u_system_bus_controller (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .dma_req_i(dma_req), .cpu_req_i(cpu_req),
      .dma_gnt_o(dma_gnt), .cpu_gnt_o(cpu_gnt), .abort_o(abort), .slave_o(slave),
      .remap_o(remap), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));

   bus_masters_model u_bus_masters_model (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cpu_gnt_i(cpu_gnt), .abort_i(abort),
      .dma_req_o(dma_req), .cpu_req_o(cpu_req), .cpu_aborts_o(cpu_aborts));

   // 50 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Register write; remap state is compared in the following cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
      if (a == REMAP_CMD_OFS && d[REMAP_TOGGLE_BIT]) m_remap = !m_remap;
      @(negedge clk_sys_i);
      chk("remap", 32'(m_remap), 32'(remap));
      @(posedge clk_sys_i);
   endtask

   // Register read; data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd <= 1'b0;
      @(negedge clk_sys_i);
      chk("rdata", exp, reg_rdata);
      @(posedge clk_sys_i);
   endtask

   // Status read; the model then drops the saved per-master flags
   task automatic rd_stat();
      logic [31:0] e;
      e = m_stat | (32'(m_src) << DMA_SRC_BIT) | (32'(m_sticky) << DMA_STICKY_BIT);
      rd(ABORT_STAT_OFS, e);
      m_sticky = 2'b00;
      m_unread = 1'b0;
   endtask

   // Predicts one taken access and compares the answer of the next cycle
   task automatic result(input bit cpu, input logic [31:0] a, input acc_size_t sz,
                         input acc_type_t k, input logic [31:0] d);
      target_t     t;
      logic [27:0] o;
      logic [7:0]  s;
      bit          und;
      bit          mis;
      und = 1'b0;
      o = a[27:0];
      t = TGT_PERIPH;
      if (a[31:28] == REGION_INTERNAL) begin
         s = (a[27:20] == SLOT_AREA0) ? (m_remap ? SLOT_SRAM : SLOT_FLASH) : a[27:20];
         t = (s == SLOT_FLASH) ? TGT_FLASH : TGT_SRAM;
         o = (s == SLOT_FLASH) ? 28'(a[FLASH_AW-1:0]) : 28'(a[SRAM_AW-1:0]);
         und = (s != SLOT_FLASH) && (s != SLOT_SRAM);
      end else if (a[31:28] != REGION_PERIPH) begin
         und = 1'b1;
      end
      mis = !(cpu && k == ACC_FETCH) &&
            ((sz == SZ_WORD && a[1:0] != 2'b00) || (sz == SZ_HALF && a[0]));
      @(negedge clk_sys_i);
      chk("abort", 32'(und | mis), 32'(abort));
      chk("valid", 32'(!(und | mis)), 32'(slave.valid));
      if (!(und | mis)) begin
         chk("target", 32'(t), 32'(slave.target));
         chk("offset", 32'(o), 32'(slave.offset));
         chk("wdata", d, slave.wdata);
         chk("write", 32'(k == ACC_WRITE), 32'(slave.write));
         chk("size", 32'(sz), 32'(slave.size));
      end else begin
         // Previous unread source moves into the saved flags
         if (m_unread) m_sticky |= m_src;
         m_src = cpu ? 2'b10 : 2'b01;
         m_stat = 32'(und) << UNDEF_FLAG_BIT | 32'(mis) << MISAL_FLAG_BIT |
                  32'(sz) << ABT_SIZE_LSB | 32'(k) << ABT_TYPE_LSB;
         m_aaddr = a;
         m_unread = 1'b1;
         m_cpu_ab += cpu;
      end
   endtask

   task automatic access(input bit cpu, input logic [31:0] a, input acc_size_t sz,
                         input acc_type_t k);
      logic [31:0] d;
      d = xs();
      u_bus_masters_model.drive(cpu, a, sz, k, d);
      @(posedge clk_sys_i);
      chk("grant", 32'h1, 32'(cpu ? cpu_gnt : dma_gnt));
      u_bus_masters_model.idle(cpu);
      result(cpu, a, sz, k, d);
      @(posedge clk_sys_i);
   endtask

   // Both masters ask at once; the processor holds until granted
   task automatic both();
      logic [31:0] d1;
      logic [31:0] d2;
      d1 = xs();
      d2 = xs();
      u_bus_masters_model.drive(0, a1, s1, k1, d1);
      u_bus_masters_model.drive(1, a2, s2, k2, d2);
      @(posedge clk_sys_i);
      chk("dma_gnt", 32'h1, 32'(dma_gnt));
      chk("cpu_gnt", 32'h0, 32'(cpu_gnt));
      u_bus_masters_model.idle(0);
      result(0, a1, s1, k1, d1);
      @(posedge clk_sys_i);
      chk("cpu_gnt", 32'h1, 32'(cpu_gnt));
      u_bus_masters_model.idle(1);
      result(1, a2, s2, k2, d2);
      @(posedge clk_sys_i);
   endtask

   // Random address biased towards the interesting slots and regions
   task automatic rnd_req(output logic [31:0] a, output acc_size_t sz, output acc_type_t k);
      logic [31:0] r;
      r = xs();
      a = xs();
      case (r[2:0])
         3'h0: a[31:20] = 12'h000;
         3'h1: a[31:20] = 12'h001;
         3'h2: a[31:20] = 12'h002;
         3'h3: a[31:28] = REGION_INTERNAL;
         3'h4: a[31:28] = REGION_PERIPH;
         default: ;
      endcase
      if (r[3]) a[1:0] = 2'b00;
      sz = (r[5:4] == 2'h3) ? SZ_WORD : acc_size_t'(r[5:4]);
      k = (r[7:6] == 2'h3) ? ACC_READ : acc_type_t'(r[7:6]);
   endtask

   initial begin
      num_errors = 0;
      checks_done = 0;
      m_remap = 1'b0;
      m_src = 2'b00;
      m_sticky = 2'b00;
      m_unread = 1'b0;
      m_stat = 32'h0;
      m_aaddr = 32'h0;
      m_cpu_ab = 0;
      seed = 32'h8ae1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rst_i = 1'b1;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      rd(ABORT_STAT_OFS, ABORT_STAT_RST);
      rd(ABORT_ADDR_OFS, ABORT_ADDR_RST);
      rd(REMAP_CMD_OFS, 32'h0);
      rd(8'h0c, 32'h0);
      $display("Reset values done");
      // Area 0, own slots and an unassigned slot, in each map state
      for (int i = 0; i < 3; i++) begin
         access(1, 32'h000f_fff0, SZ_WORD, ACC_READ);
         access(0, 32'h0010_0012, SZ_HALF, ACC_WRITE);
         access(0, 32'h0024_0003, SZ_BYTE, ACC_WRITE);
         access(1, 32'h0030_0000, SZ_WORD, ACC_READ);
         wr(REMAP_CMD_OFS, 32'hffff_fffe);
         wr(REMAP_CMD_OFS, 32'h0000_0001);
      end
      $display("Remap test done");
      // Abort causes, sources and saved flags
      access(0, 32'h0000_0002, SZ_WORD, ACC_WRITE);
      access(1, 32'h0000_0002, SZ_WORD, ACC_FETCH);
      access(0, 32'h0010_0001, SZ_WORD, ACC_FETCH);
      access(1, 32'h1000_0001, SZ_HALF, ACC_READ);
      rd(ABORT_ADDR_OFS, m_aaddr);
      rd_stat();
      rd_stat();
      access(1, 32'he123_4567, SZ_BYTE, ACC_READ);
      access(1, 32'hf000_0100, SZ_WORD, ACC_WRITE);
      rd_stat();
      $display("Abort test done");
      for (int i = 0; i < 150; i++) begin
         rnd_req(a1, s1, k1);
         rnd_req(a2, s2, k2);
         if (a1[4]) begin
            both();
         end else begin
            access(a2[5], a1, s1, k1);
         end
         if (i % 8 == 7) rd_stat();
         if (i % 8 == 3) rd(ABORT_ADDR_OFS, m_aaddr);
         if (i % 16 == 5) wr(REMAP_CMD_OFS, xs());
      end
      chk("cpu_aborts", m_cpu_ab, cpu_aborts);
      $display("Random test done");
      end_of_test();
   end
endmodule // tb_system_bus_controller

`default_nettype wire
